// File: core/mmw_pkg.sv
// Constants and types shared by the memory map and wait-state decoder.
// Assumes a 22-bit word address and a 32-bit register port.
package mmw_pkg;
    localparam int ADDR_W = 22;
    localparam int WAIT_W = 5;

    typedef logic [ADDR_W-1:0] mmw_addr_t;
    typedef logic [WAIT_W-1:0] mmw_wait_t;

    // One access from the core
    typedef struct packed {
        mmw_addr_t addr;
        logic write;
        logic prog;
        logic io;
    } mmw_acc_t;

    typedef enum logic [3:0] {
        RG_NONE = 4'h0, RG_M01 = 4'h1, RG_PF0 = 4'h2, RG_PF1 = 4'h3,
        RG_PF2 = 4'h4, RG_L01 = 4'h5, RG_OTP = 4'h6, RG_FLASH = 4'h7,
        RG_H0 = 4'h8, RG_BROM = 4'h9, RG_XZ0 = 4'hA, RG_XZ1 = 4'hB,
        RG_XZ2 = 4'hC, RG_XZ6 = 4'hD, RG_XZ7 = 4'hE
    } mmw_region_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } mmw_state_t;

    // Region bounds, word addresses
    localparam mmw_addr_t M01_LO = 22'h000000, M01_HI = 22'h0007FF;
    localparam mmw_addr_t PF0_LO = 22'h000800, PF0_HI = 22'h001FFF;
    localparam mmw_addr_t XZ0_LO = 22'h002000, XZ0_HI = 22'h003FFF;
    localparam mmw_addr_t XZ1_LO = 22'h004000, XZ1_HI = 22'h005FFF;
    localparam mmw_addr_t PF1_LO = 22'h006000, PF1_HI = 22'h006FFF;
    localparam mmw_addr_t PF2_LO = 22'h007000, PF2_HI = 22'h007FFF;
    localparam mmw_addr_t L01_LO = 22'h008000, L01_HI = 22'h009FFF;
    localparam mmw_addr_t XZ2_LO = 22'h080000, XZ2_HI = 22'h0FFFFF;
    localparam mmw_addr_t XZ6_LO = 22'h100000, XZ6_HI = 22'h17FFFF;
    localparam mmw_addr_t OTP_LO = 22'h3D7800, OTP_HI = 22'h3D7BFF;
    localparam mmw_addr_t FL_LO = 22'h3D8000, FL_HI = 22'h3F7FFF;
    localparam mmw_addr_t PWD_LO = 22'h3F7FF8;
    localparam mmw_addr_t H0_LO = 22'h3F8000, H0_HI = 22'h3F9FFF;
    localparam mmw_addr_t XZ7_LO = 22'h3FC000, XZ7_HI = 22'h3FFFFF;
    localparam mmw_addr_t BROM_LO = 22'h3FF000, BROM_HI = 22'h3FFFFF;
    localparam mmw_addr_t GRD_LO = 22'h000880, GRD_HI = 22'h0009FF;
    // Upper bounds of sectors J..B; sector A runs to FL_HI
    localparam mmw_addr_t SEC_HI [9] = '{22'h3D9FFF, 22'h3DBFFF, 22'h3DFFFF,
        22'h3E3FFF, 22'h3E7FFF, 22'h3EBFFF, 22'h3EFFFF, 22'h3F3FFF, 22'h3F5FFF};
    localparam logic [5:0] LEGACY_PROG_PAGE = 6'h3F;

    // Fixed waits
    localparam mmw_wait_t WS_ZERO = 5'h00;
    localparam mmw_wait_t WS_BROM = 5'h01;
    localparam mmw_wait_t WS_PF_RD = 5'h02;
    localparam mmw_wait_t WS_PWD = 5'h10;
    localparam mmw_wait_t WS_MIN_ONE = 5'h01;
    localparam mmw_wait_t WS_PROT_ALIGN = 5'h01;

    // Register offsets (byte addresses) and fields
    localparam logic [7:0] OFS_ZONE0 = 8'h00; // zones 0,1,2,6,7 at 0x00..0x10
    localparam logic [7:0] OFS_FLASH_WAIT = 8'h14;
    localparam logic [7:0] OFS_CONFIG = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam int ZONE_CNT = 5;
    localparam int ZF_READY = 4;
    localparam int CF_EXT_BOOT = 0;
    localparam int CF_PROTECT = 1;
    localparam int SF_BLOCKED = 0;
    localparam int SF_UNMAPPED = 1;
    localparam int SF_BUSY = 4;

    // Reset values
    localparam logic [4:0] RST_ZONE = 5'h16;
    localparam logic [3:0] RST_FLASH_WS = 4'hF;
    localparam logic [3:0] RST_OTP_WS = 4'hF;
    localparam logic RST_PROTECT = 1'b1;
endpackage : mmw_pkg

// File: core/mmw_decoder.sv
// Memory map decoder and wait-state sequencer.
// Assumes core inputs synchronous to CORE_CLK; one access at a time.
`timescale 1ns/10ps
`default_nettype none
module mmw_decoder (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Core access
    input wire logic CPU_REQ,
    input wire mmw_pkg::mmw_acc_t CPU_ACC,
    output logic CPU_BUSY,
    output logic CPU_ACK,
    output logic CPU_ERR,
    // Target side
    output mmw_pkg::mmw_region_t TGT_REGION,
    output logic [3:0] TGT_SECTOR,
    output logic [21:0] TGT_ADDR,
    output logic TGT_WR,
    output logic CS_ZONES_LOW_N,
    output logic CS_ZONE2_N,
    output logic CS_ZONES_HIGH_N,
    output logic BOOT_ROM_EN,
    output logic VECTOR_EXTERNAL,
    // Pins and core status
    input wire logic BOOT_SOURCE_SELECT_PIN,
    input wire logic EXT_READY,
    input wire logic WRITE_UNLOCK_GUARD,
    input wire logic LEGACY_MODE
);
    function automatic logic in_rng(input mmw_pkg::mmw_addr_t a,
                                    input mmw_pkg::mmw_addr_t lo,
                                    input mmw_pkg::mmw_addr_t hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    // Configuration registers
    logic [4:0] zone_cfg_ff [mmw_pkg::ZONE_CNT];
    logic [4:0] nxt_zone_cfg [mmw_pkg::ZONE_CNT];
    logic [3:0] flash_ws_ff, nxt_flash_ws, otp_ws_ff, nxt_otp_ws;
    logic ext_boot_ff, nxt_ext_boot, protect_ff, nxt_protect;
    logic boot_taken_ff, nxt_boot_taken;
    logic blocked_ff, nxt_blocked, unmapped_ff, nxt_unmapped;
    logic [31:0] rdata_ff, nxt_rdata;

    // Access sequencer
    mmw_pkg::mmw_state_t state_ff, nxt_state;
    mmw_pkg::mmw_wait_t cnt_ff, nxt_cnt;
    mmw_pkg::mmw_region_t region_ff, nxt_region;
    logic [3:0] sector_ff, nxt_sector;
    logic [21:0] taddr_ff, nxt_taddr;
    logic twr_ff, nxt_twr, use_rdy_ff, nxt_use_rdy, err_ff, nxt_err;
    logic last_pwr_ff, nxt_last_pwr;
    mmw_pkg::mmw_addr_t last_addr_ff, nxt_last_addr;

    // Decode of the incoming access
    mmw_pkg::mmw_addr_t dec_addr;
    mmw_pkg::mmw_region_t dec_region;
    mmw_pkg::mmw_wait_t dec_wait;
    logic [3:0] dec_sector;
    logic dec_rdy, dec_prot, dec_block;
    int zi;

    always_comb begin
        dec_addr = CPU_ACC.addr;
        // Legacy code sees two 64K windows only
        if (LEGACY_MODE)
            dec_addr[21:16] = CPU_ACC.prog ? mmw_pkg::LEGACY_PROG_PAGE : 6'h00;
        dec_region = mmw_pkg::RG_NONE;
        dec_sector = 4'h0;
        zi = 0;
        if (in_rng(dec_addr, mmw_pkg::M01_LO, mmw_pkg::M01_HI)) begin
            dec_region = mmw_pkg::RG_M01;
        end else if (in_rng(dec_addr, mmw_pkg::PF0_LO, mmw_pkg::PF0_HI)) begin
            dec_region = CPU_ACC.prog ? mmw_pkg::RG_NONE : mmw_pkg::RG_PF0;
        end else if (in_rng(dec_addr, mmw_pkg::PF1_LO, mmw_pkg::PF1_HI)) begin
            dec_region = CPU_ACC.prog ? mmw_pkg::RG_NONE : mmw_pkg::RG_PF1;
        end else if (in_rng(dec_addr, mmw_pkg::PF2_LO, mmw_pkg::PF2_HI)) begin
            dec_region = CPU_ACC.prog ? mmw_pkg::RG_NONE : mmw_pkg::RG_PF2;
        end else if (in_rng(dec_addr, mmw_pkg::L01_LO, mmw_pkg::L01_HI)) begin
            dec_region = mmw_pkg::RG_L01;
        end else if (in_rng(dec_addr, mmw_pkg::XZ0_LO, mmw_pkg::XZ0_HI)) begin
            dec_region = mmw_pkg::RG_XZ0;
        end else if (in_rng(dec_addr, mmw_pkg::XZ1_LO, mmw_pkg::XZ1_HI)) begin
            dec_region = mmw_pkg::RG_XZ1;
        end else if (in_rng(dec_addr, mmw_pkg::XZ2_LO, mmw_pkg::XZ2_HI)) begin
            dec_region = mmw_pkg::RG_XZ2;
        end else if (in_rng(dec_addr, mmw_pkg::XZ6_LO, mmw_pkg::XZ6_HI)) begin
            dec_region = mmw_pkg::RG_XZ6;
        end else if (in_rng(dec_addr, mmw_pkg::OTP_LO, mmw_pkg::OTP_HI)) begin
            dec_region = mmw_pkg::RG_OTP;
        end else if (in_rng(dec_addr, mmw_pkg::FL_LO, mmw_pkg::FL_HI)) begin
            dec_region = mmw_pkg::RG_FLASH;
            // Sector index: J is 0, A is 9
            for (int i = 0; i < 9; i++) begin
                if (dec_addr > mmw_pkg::SEC_HI[i]) dec_sector = 4'(i + 1);
            end
        end else if (in_rng(dec_addr, mmw_pkg::H0_LO, mmw_pkg::H0_HI)) begin
            dec_region = mmw_pkg::RG_H0;
        end else if (ext_boot_ff && in_rng(dec_addr, mmw_pkg::XZ7_LO, mmw_pkg::XZ7_HI)) begin
            dec_region = mmw_pkg::RG_XZ7;
        end else if (!ext_boot_ff && in_rng(dec_addr, mmw_pkg::BROM_LO, mmw_pkg::BROM_HI)) begin
            dec_region = mmw_pkg::RG_BROM;
        end
        // No I/O space anywhere, external port included
        if (CPU_ACC.io) dec_region = mmw_pkg::RG_NONE;
        dec_rdy = 1'b0;
        unique case (dec_region)
            mmw_pkg::RG_PF1, mmw_pkg::RG_PF2: begin
                dec_wait = CPU_ACC.write ? mmw_pkg::WS_ZERO : mmw_pkg::WS_PF_RD;
            end
            mmw_pkg::RG_BROM: begin
                dec_wait = mmw_pkg::WS_BROM;
            end
            mmw_pkg::RG_OTP: begin
                dec_wait = {1'b0, otp_ws_ff};
                if (dec_wait < mmw_pkg::WS_MIN_ONE) dec_wait = mmw_pkg::WS_MIN_ONE;
            end
            mmw_pkg::RG_FLASH: begin
                if (dec_addr >= mmw_pkg::PWD_LO) begin
                    dec_wait = mmw_pkg::WS_PWD;
                end else begin
                    dec_wait = {1'b0, flash_ws_ff};
                end
            end
            mmw_pkg::RG_XZ0, mmw_pkg::RG_XZ1, mmw_pkg::RG_XZ2,
            mmw_pkg::RG_XZ6, mmw_pkg::RG_XZ7: begin
                zi = int'(dec_region) - int'(mmw_pkg::RG_XZ0);
                dec_wait = {1'b0, zone_cfg_ff[zi][3:0]};
                dec_rdy = zone_cfg_ff[zi][mmw_pkg::ZF_READY];
                if (dec_wait < mmw_pkg::WS_MIN_ONE) dec_wait = mmw_pkg::WS_MIN_ONE;
            end
            default: begin
                dec_wait = mmw_pkg::WS_ZERO;
            end
        endcase
        dec_prot = (dec_region == mmw_pkg::RG_PF1) || (dec_region == mmw_pkg::RG_PF2)
            || (dec_region == mmw_pkg::RG_XZ1);
        // Write then read elsewhere would swap; stall the read
        if (protect_ff && dec_prot && !CPU_ACC.write && last_pwr_ff
            && (dec_addr != last_addr_ff))
            dec_wait = mmw_pkg::mmw_wait_t'(dec_wait + mmw_pkg::WS_PROT_ALIGN);
        dec_block = CPU_ACC.write && !WRITE_UNLOCK_GUARD
            && (in_rng(dec_addr, mmw_pkg::GRD_LO, mmw_pkg::GRD_HI)
            || dec_region == mmw_pkg::RG_PF1);
    end

    logic take, done;
    assign take = (state_ff == mmw_pkg::ST_IDLE) && CPU_REQ;
    // Ready stretches only once the count is spent
    assign done = (state_ff == mmw_pkg::ST_BUSY) && (cnt_ff == mmw_pkg::WS_ZERO)
        && (!use_rdy_ff || EXT_READY);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_region = region_ff;
        nxt_sector = sector_ff;
        nxt_taddr = taddr_ff;
        nxt_twr = twr_ff;
        nxt_use_rdy = use_rdy_ff;
        nxt_err = err_ff;
        nxt_last_pwr = last_pwr_ff;
        nxt_last_addr = last_addr_ff;
        unique case (state_ff)
            mmw_pkg::ST_IDLE: begin
                if (take) begin
                    nxt_state = mmw_pkg::ST_BUSY;
                    nxt_cnt = dec_wait;
                    nxt_region = dec_block ? mmw_pkg::RG_NONE : dec_region;
                    nxt_sector = dec_sector;
                    nxt_taddr = dec_addr;
                    nxt_twr = CPU_ACC.write;
                    nxt_use_rdy = dec_rdy && !dec_block;
                    nxt_err = dec_block || (dec_region == mmw_pkg::RG_NONE);
                    nxt_last_pwr = CPU_ACC.write && dec_prot && !dec_block;
                    nxt_last_addr = dec_addr;
                end
            end
            mmw_pkg::ST_BUSY: begin
                if (done) begin
                    nxt_state = mmw_pkg::ST_IDLE;
                    nxt_region = mmw_pkg::RG_NONE;
                    nxt_twr = 1'b0;
                    nxt_err = 1'b0;
                    nxt_use_rdy = 1'b0;
                end else if (cnt_ff != mmw_pkg::WS_ZERO) begin
                    nxt_cnt = mmw_pkg::mmw_wait_t'(cnt_ff - 5'h01);
                end
            end
        endcase
    end

    // Register file
    always_comb begin
        nxt_zone_cfg = zone_cfg_ff;
        nxt_flash_ws = flash_ws_ff;
        nxt_otp_ws = otp_ws_ff;
        nxt_ext_boot = ext_boot_ff;
        nxt_protect = protect_ff;
        nxt_boot_taken = 1'b1;
        nxt_blocked = blocked_ff;
        nxt_unmapped = unmapped_ff;
        nxt_rdata = 32'h00000000;
        // Strap caught on the first edge after reset
        if (!boot_taken_ff) nxt_ext_boot = BOOT_SOURCE_SELECT_PIN;
        if (REG_WR) begin
            for (int i = 0; i < mmw_pkg::ZONE_CNT; i++) begin
                if (REG_ADDR == mmw_pkg::OFS_ZONE0 + 8'(4 * i))
                    nxt_zone_cfg[i] = REG_WDATA[4:0];
            end
            unique case (REG_ADDR)
                mmw_pkg::OFS_FLASH_WAIT: begin
                    nxt_flash_ws = REG_WDATA[3:0];
                    nxt_otp_ws = REG_WDATA[7:4];
                end
                mmw_pkg::OFS_CONFIG: begin
                    // ROM, zone 7 and the vector select follow this bit
                    nxt_ext_boot = REG_WDATA[mmw_pkg::CF_EXT_BOOT];
                    nxt_protect = REG_WDATA[mmw_pkg::CF_PROTECT];
                end
                mmw_pkg::OFS_STATUS: begin
                    nxt_blocked = blocked_ff & ~REG_WDATA[mmw_pkg::SF_BLOCKED];
                    nxt_unmapped = unmapped_ff & ~REG_WDATA[mmw_pkg::SF_UNMAPPED];
                end
                default: ;
            endcase
        end
        // Set beats a clear in the same cycle
        if (take && dec_block) nxt_blocked = 1'b1;
        if (take && !dec_block && dec_region == mmw_pkg::RG_NONE) nxt_unmapped = 1'b1;
        if (REG_RD) begin
            for (int i = 0; i < mmw_pkg::ZONE_CNT; i++) begin
                if (REG_ADDR == mmw_pkg::OFS_ZONE0 + 8'(4 * i))
                    nxt_rdata = {27'h0, zone_cfg_ff[i]};
            end
            if (REG_ADDR == mmw_pkg::OFS_FLASH_WAIT) nxt_rdata = {24'h0, otp_ws_ff, flash_ws_ff};
            if (REG_ADDR == mmw_pkg::OFS_CONFIG) nxt_rdata = {30'h0, protect_ff, ext_boot_ff};
            if (REG_ADDR == mmw_pkg::OFS_STATUS)
                nxt_rdata = {27'h0, (state_ff == mmw_pkg::ST_BUSY), 2'h0, unmapped_ff, blocked_ff};
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < mmw_pkg::ZONE_CNT; i++) begin
                zone_cfg_ff[i] <= mmw_pkg::RST_ZONE;
            end
            flash_ws_ff <= mmw_pkg::RST_FLASH_WS;
            otp_ws_ff <= mmw_pkg::RST_OTP_WS;
            ext_boot_ff <= 1'b0;
            protect_ff <= mmw_pkg::RST_PROTECT;
            boot_taken_ff <= 1'b0;
            blocked_ff <= 1'b0;
            unmapped_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            state_ff <= mmw_pkg::ST_IDLE;
            cnt_ff <= mmw_pkg::WS_ZERO;
            region_ff <= mmw_pkg::RG_NONE;
            sector_ff <= 4'h0;
            taddr_ff <= 22'h000000;
            twr_ff <= 1'b0;
            use_rdy_ff <= 1'b0;
            err_ff <= 1'b0;
            last_pwr_ff <= 1'b0;
            last_addr_ff <= 22'h000000;
        end else begin
            zone_cfg_ff <= nxt_zone_cfg;
            flash_ws_ff <= nxt_flash_ws;
            otp_ws_ff <= nxt_otp_ws;
            ext_boot_ff <= nxt_ext_boot;
            protect_ff <= nxt_protect;
            boot_taken_ff <= nxt_boot_taken;
            blocked_ff <= nxt_blocked;
            unmapped_ff <= nxt_unmapped;
            rdata_ff <= nxt_rdata;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            region_ff <= nxt_region;
            sector_ff <= nxt_sector;
            taddr_ff <= nxt_taddr;
            twr_ff <= nxt_twr;
            use_rdy_ff <= nxt_use_rdy;
            err_ff <= nxt_err;
            last_pwr_ff <= nxt_last_pwr;
            last_addr_ff <= nxt_last_addr;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign CPU_BUSY = (state_ff == mmw_pkg::ST_BUSY);
    assign CPU_ACK = done;
    assign CPU_ERR = done && err_ff;
    assign TGT_REGION = region_ff;
    assign TGT_SECTOR = sector_ff;
    assign TGT_ADDR = taddr_ff;
    assign TGT_WR = twr_ff;
    // Paired zones share a select, so they mirror
    assign CS_ZONES_LOW_N = !(region_ff == mmw_pkg::RG_XZ0 || region_ff == mmw_pkg::RG_XZ1);
    assign CS_ZONE2_N = !(region_ff == mmw_pkg::RG_XZ2);
    assign CS_ZONES_HIGH_N = !(region_ff == mmw_pkg::RG_XZ6 || region_ff == mmw_pkg::RG_XZ7);
    assign BOOT_ROM_EN = !ext_boot_ff;
    assign VECTOR_EXTERNAL = ext_boot_ff;
endmodule : mmw_decoder
`default_nettype wire

// File: tb/mmw_decoder_asserts.sv
// Checker for core-side and chip-select behaviour.
// Bound to mmw_decoder; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mmw_decoder_asserts (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Core side
    input wire logic CPU_REQ,
    input wire mmw_pkg::mmw_acc_t CPU_ACC,
    input wire logic CPU_BUSY,
    input wire logic CPU_ACK,
    // Target side and legacy mode
    input wire mmw_pkg::mmw_region_t TGT_REGION,
    input wire logic CS_ZONES_LOW_N,
    input wire logic CS_ZONE2_N,
    input wire logic CS_ZONES_HIGH_N,
    input wire logic BOOT_ROM_EN,
    input wire logic VECTOR_EXTERNAL,
    input wire logic LEGACY_MODE
);
    default clocking cb_main @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);
    logic take, plain;
    mmw_pkg::mmw_addr_t a;
    assign take = CPU_REQ && !CPU_BUSY;
    // Legacy and I/O accesses kept out
    assign plain = take && !CPU_ACC.io && !LEGACY_MODE;
    assign a = CPU_ACC.addr;
    a_shared_low_cs: assert property (
        (TGT_REGION inside {mmw_pkg::RG_XZ0, mmw_pkg::RG_XZ1}) == !CS_ZONES_LOW_N)
        else $error("zone 0/1 select wrong");
    a_shared_high_cs: assert property (
        (TGT_REGION inside {mmw_pkg::RG_XZ6, mmw_pkg::RG_XZ7}) == !CS_ZONES_HIGH_N)
        else $error("zone 6/7 select wrong");
    a_ext_min_wait: assert property (
        $fell(CS_ZONES_LOW_N) || $fell(CS_ZONE2_N) || $fell(CS_ZONES_HIGH_N) |-> !CPU_ACK)
        else $error("external access without wait");
    a_no_io_ext: assert property (take && CPU_ACC.io |=>
        CS_ZONES_LOW_N && CS_ZONE2_N && CS_ZONES_HIGH_N)
        else $error("I/O access on external port");
    a_pf_data_only: assert property (plain && CPU_ACC.prog && (a inside
        {[mmw_pkg::PF0_LO:mmw_pkg::PF0_HI], [mmw_pkg::PF1_LO:mmw_pkg::PF2_HI]}) |=>
        !(TGT_REGION inside {mmw_pkg::RG_PF0, mmw_pkg::RG_PF1, mmw_pkg::RG_PF2}))
        else $error("program access hit a frame");
    a_boot_exclusive: assert property (BOOT_ROM_EN != VECTOR_EXTERNAL)
        else $error("boot sources not exclusive");
    a_zone7_off: assert property (plain && BOOT_ROM_EN && a >= mmw_pkg::XZ7_LO |=>
        CS_ZONES_HIGH_N)
        else $error("zone 7 selected in ROM mode");
    a_rom_one_wait: assert property (plain && !CPU_ACC.write && BOOT_ROM_EN &&
        a >= mmw_pkg::BROM_LO |=> !CPU_ACK ##1 CPU_ACK)
        else $error("boot ROM wait wrong");
    a_pwd_sixteen: assert property (plain && !CPU_ACC.write && a >= mmw_pkg::PWD_LO &&
        a <= mmw_pkg::FL_HI |=> (!CPU_ACK)[*8] ##1 (!CPU_ACK)[*8] ##1 CPU_ACK)
        else $error("password wait wrong");
    a_ram_zero: assert property (plain && a <= mmw_pkg::M01_HI |=> CPU_ACK)
        else $error("low RAM wait wrong");
endmodule : mmw_decoder_asserts
bind mmw_decoder mmw_decoder_asserts chk_u (.CORE_CLK, .NRST, .CPU_REQ, .CPU_ACC, .CPU_BUSY,
    .CPU_ACK, .TGT_REGION, .CS_ZONES_LOW_N, .CS_ZONE2_N, .CS_ZONES_HIGH_N, .BOOT_ROM_EN,
    .VECTOR_EXTERNAL, .LEGACY_MODE);
`default_nettype wire

// File: tb/mmw_core_model.sv
// Core model: issues one access on command and times its answer.
// Assumes a request is taken while busy is low; ack lasts one cycle.
`timescale 1ns/10ps
`default_nettype none
module mmw_core_model (
    // Clock and bench control
    input wire logic clk,
    input wire logic start,
    input wire mmw_pkg::mmw_acc_t start_acc,
    output logic done,
    output int lat,
    // Decoder side
    output logic req,
    output mmw_pkg::mmw_acc_t acc,
    input wire logic busy,
    input wire logic ack
);
    // No flash image held here
    logic wait_ff = 1'b0;
    initial begin
        req = 1'b0;
        acc = '0;
        done = 1'b0;
        lat = 0;
    end
    always @(posedge clk) begin
        done <= 1'b0;
        if (start) begin
            req <= 1'b1;
            acc <= start_acc;
        end else if (req && !busy) begin
            // Released lines show the inverse, not the old request
            req <= 1'b0;
            acc <= ~acc;
            wait_ff <= 1'b1;
            lat <= 1;
        end else if (wait_ff && ack) begin
            wait_ff <= 1'b0;
            done <= 1'b1;
        end else if (wait_ff) begin
            lat <= lat + 1;
        end
    end
endmodule : mmw_core_model
`default_nettype wire

// File: tb/mmw_decoder_bench.sv
// Self-checking bench for the decoder.
// Assumes the core model and checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module mmw_decoder_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr_s = 1'b0;
    logic reg_rd_s = 1'b0;
    logic boot_pin = 1'b0;
    logic ext_ready = 1'b1;
    logic guard = 1'b0;
    logic legacy = 1'b0;
    logic start = 1'b0;
    mmw_pkg::mmw_acc_t start_acc = '0;
    mmw_pkg::mmw_acc_t cpu_acc;
    mmw_pkg::mmw_region_t tgt_region, reg_q;
    logic [31:0] reg_rdata, d;
    logic [21:0] tgt_addr;
    logic [3:0] tgt_sector, sec_q, fw, ow;
    logic [4:0] zw;
    logic cpu_req, cpu_busy, cpu_ack, cpu_err, err_q, done;
    logic tgt_wr, cs_lo_n, cs_z2_n, cs_hi_n, rom_en, vec_ext;
    int lat, n_fail = 0, checked = 0, cycles = 0;
    mmw_pkg::mmw_addr_t fix_a [5] = '{mmw_pkg::M01_LO, mmw_pkg::L01_LO, mmw_pkg::H0_LO,
        mmw_pkg::BROM_LO, mmw_pkg::PF0_LO};
    mmw_pkg::mmw_region_t fix_r [5] = '{mmw_pkg::RG_M01, mmw_pkg::RG_L01, mmw_pkg::RG_H0,
        mmw_pkg::RG_BROM, mmw_pkg::RG_PF0};
    mmw_pkg::mmw_addr_t zlo [5] = '{mmw_pkg::XZ0_LO, mmw_pkg::XZ1_LO, mmw_pkg::XZ2_LO,
        mmw_pkg::XZ6_LO, mmw_pkg::XZ7_LO};
    mmw_pkg::mmw_region_t zrg [5] = '{mmw_pkg::RG_XZ0, mmw_pkg::RG_XZ1, mmw_pkg::RG_XZ2,
        mmw_pkg::RG_XZ6, mmw_pkg::RG_XZ7};
    mmw_decoder dut_u (.CORE_CLK(clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr_s), .REG_RD(reg_rd_s), .REG_RDATA(reg_rdata), .CPU_REQ(cpu_req),
        .CPU_ACC(cpu_acc), .CPU_BUSY(cpu_busy), .CPU_ACK(cpu_ack), .CPU_ERR(cpu_err),
        .TGT_REGION(tgt_region), .TGT_SECTOR(tgt_sector), .TGT_ADDR(tgt_addr), .TGT_WR(tgt_wr),
        .CS_ZONES_LOW_N(cs_lo_n), .CS_ZONE2_N(cs_z2_n), .CS_ZONES_HIGH_N(cs_hi_n),
        .BOOT_ROM_EN(rom_en), .VECTOR_EXTERNAL(vec_ext), .BOOT_SOURCE_SELECT_PIN(boot_pin),
        .EXT_READY(ext_ready), .WRITE_UNLOCK_GUARD(guard), .LEGACY_MODE(legacy));
    mmw_core_model core_u (.clk(clk), .start(start), .start_acc(start_acc), .done(done),
        .lat(lat), .req(cpu_req), .acc(cpu_acc), .busy(cpu_busy), .ack(cpu_ack));
    initial begin
        forever #2 clk = ~clk;
    end
    // Zones are written with the ready bit clear, so this noise must not matter
    always @(posedge clk) begin
        ext_ready <= 1'($urandom_range(1));
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            close_out;
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic int wait1(input int w);
        return (w == 0) ? 2 : w + 1;
    endfunction : wait1
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr_s <= 1'b1;
        @(posedge clk);
        reg_wr_s <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_s <= 1'b1;
        @(posedge clk);
        reg_rd_s <= 1'b0;
        #1;
        check("register", reg_rdata, exp);
    endtask : rd_reg
    task automatic acc_chk(input mmw_pkg::mmw_addr_t a, input logic w, input logic p,
        input logic io, input int exp_lat, input logic exp_err, input mmw_pkg::mmw_region_t rg);
        int n = 0;
        @(posedge clk);
        start <= 1'b1;
        start_acc <= '{addr: a, write: w, prog: p, io: io};
        @(posedge clk);
        start <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (cpu_ack === 1'b1) begin
                err_q = cpu_err;
                reg_q = tgt_region;
                sec_q = tgt_sector;
                check("write", 32'(tgt_wr), 32'(w));
            end
        end while (done !== 1'b1 && n < 100);
        if (n >= 100) n_fail++;
        if (exp_lat >= 0) check("latency", lat, exp_lat);
        check("error", 32'(err_q), 32'(exp_err));
        check("region", 32'(reg_q), 32'(rg));
    endtask : acc_chk
    initial begin
        d = $urandom(32'h1DCF);
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        rd_reg(mmw_pkg::OFS_CONFIG, 32'h2);
        rd_reg(mmw_pkg::OFS_ZONE0, 32'h16);
        rd_reg(mmw_pkg::OFS_FLASH_WAIT, 32'hFF);
        rd_reg(8'h20, 32'h0);
        for (int i = 0; i < 5; i++) begin
            acc_chk(fix_a[i] + 22'($urandom_range(63)), 1'b0, i[0], 1'b0, (i == 3) ? 2 : 1,
                1'b0, fix_r[i]);
        end
        acc_chk(mmw_pkg::PF2_LO, 1'b1, 1'b0, 1'b0, 1, 1'b0, mmw_pkg::RG_PF2);
        acc_chk(mmw_pkg::PF2_LO + 22'h4, 1'b0, 1'b0, 1'b0, 4, 1'b0, mmw_pkg::RG_PF2);
        wr_reg(mmw_pkg::OFS_CONFIG, 32'h0);
        acc_chk(mmw_pkg::PF2_LO, 1'b1, 1'b0, 1'b0, 1, 1'b0, mmw_pkg::RG_PF2);
        acc_chk(mmw_pkg::PF2_LO + 22'h4, 1'b0, 1'b0, 1'b0, 3, 1'b0, mmw_pkg::RG_PF2);
        wr_reg(mmw_pkg::OFS_CONFIG, 32'h2);
        acc_chk(mmw_pkg::GRD_LO, 1'b1, 1'b0, 1'b0, -1, 1'b1, mmw_pkg::RG_NONE);
        acc_chk(mmw_pkg::PF0_LO, 1'b0, 1'b1, 1'b0, -1, 1'b1, mmw_pkg::RG_NONE);
        rd_reg(mmw_pkg::OFS_STATUS, 32'h3);
        wr_reg(mmw_pkg::OFS_STATUS, 32'h3);
        rd_reg(mmw_pkg::OFS_STATUS, 32'h0);
        @(posedge clk);
        guard <= 1'b1;
        acc_chk(mmw_pkg::GRD_LO, 1'b1, 1'b0, 1'b0, 1, 1'b0, mmw_pkg::RG_PF0);
        acc_chk(mmw_pkg::PF1_LO, 1'b1, 1'b0, 1'b0, 1, 1'b0, mmw_pkg::RG_PF1);
        acc_chk(mmw_pkg::XZ2_LO, 1'b0, 1'b0, 1'b1, -1, 1'b1, mmw_pkg::RG_NONE);
        for (int z = 0; z < 5; z++) begin
            zw = 5'($urandom_range(15));
            wr_reg(8'(z * 4), {27'h0, zw});
            if (z == 4) wr_reg(mmw_pkg::OFS_CONFIG, 32'h3);
            acc_chk(zlo[z] + 22'h10, 1'b1, 1'b0, 1'b0, wait1(zw), 1'b0, zrg[z]);
        end
        acc_chk(mmw_pkg::BROM_LO, 1'b0, 1'b0, 1'b0, wait1(zw), 1'b0, mmw_pkg::RG_XZ7);
        check("rom_en", 32'(rom_en), 32'h0);
        check("vec_ext", 32'(vec_ext), 32'h1);
        acc_chk(mmw_pkg::M01_LO, 1'b0, 1'b0, 1'b0, 1, 1'b0, mmw_pkg::RG_M01);
        wr_reg(mmw_pkg::OFS_FLASH_WAIT, 32'h0);
        acc_chk(mmw_pkg::OTP_LO, 1'b0, 1'b1, 1'b0, 2, 1'b0, mmw_pkg::RG_OTP);
        for (int i = 0; i < 10; i++) begin
            acc_chk((i == 0) ? mmw_pkg::FL_LO : mmw_pkg::SEC_HI[i - 1] + 22'h1, 1'b0, i[0],
                1'b0, 1, 1'b0, mmw_pkg::RG_FLASH);
            check("sector", 32'(sec_q), 32'(i));
        end
        fw = 4'($urandom_range(15));
        ow = 4'($urandom_range(15));
        wr_reg(mmw_pkg::OFS_FLASH_WAIT, {24'h0, ow, fw});
        acc_chk(mmw_pkg::FL_LO + 22'h40, 1'b0, 1'b0, 1'b0, fw + 1, 1'b0, mmw_pkg::RG_FLASH);
        acc_chk(mmw_pkg::OTP_LO + 22'h5, 1'b0, 1'b0, 1'b0, wait1(ow), 1'b0, mmw_pkg::RG_OTP);
        acc_chk(mmw_pkg::PWD_LO + 22'($urandom_range(7)), 1'b0, 1'b0, 1'b0, 17, 1'b0,
            mmw_pkg::RG_FLASH);
        @(posedge clk);
        legacy <= 1'b1;
        acc_chk(22'h008000, 1'b0, 1'b1, 1'b0, 1, 1'b0, mmw_pkg::RG_H0);
        check("taddr", 32'(tgt_addr), 32'h003F8000);
        acc_chk(22'h008000, 1'b0, 1'b0, 1'b0, 1, 1'b0, mmw_pkg::RG_L01);
        close_out;
    end
endmodule : mmw_decoder_bench
`default_nettype wire
